// [ddm_pkg.sv]
// Purpose: shared constants and types for the double-data-rate module port
// Assumes: link clock is the resolved true/complement clock crossing
// Notes:   command code is {row_strobe_n, col_strobe_n, write_enable_n}
package ddm_pkg;

    // ==========================================================
    // widths
    localparam int DATA_W = 64;
    localparam int BYTES  = 8;
    localparam int BANKS  = 4;
    localparam int BANK_W = 2;
    localparam int ADDR_W = 13;
    localparam int AP_BIT = 10;

    // ==========================================================
    // mode register fields and codes
    localparam int         MR_BL_LSB = 0;
    localparam int         MR_BT_BIT = 3;
    localparam int         MR_CL_LSB = 4;
    localparam logic [2:0] BL2_CODE  = 3'h1;
    localparam logic [2:0] BL4_CODE  = 3'h2;
    localparam logic [2:0] BL8_CODE  = 3'h3;
    localparam logic [2:0] CL2_CODE  = 3'h2;
    localparam logic [2:0] CL3_CODE  = 3'h3;
    localparam logic [2:0] CL25_CODE = 3'h6;
    localparam logic [3:0] BL_RST    = 4'h4;
    localparam logic [1:0] CL_RST    = 2'h2;
    localparam logic       BT_RST    = 1'b0;

    // ==========================================================
    // timing
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         TRP_NS        = 15;
    localparam int         TRP_CYC_I     = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] TRP_CYC       = 4'(TRP_CYC_I);

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        CMD_MRS = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
        CMD_WR  = 3'h4, CMD_RD  = 3'h5, CMD_BST = 3'h6, CMD_NOP = 3'h7
    } ddm_op_t;

    typedef enum logic [4:0] {
        ST_IDLE     = 5'h01,
        ST_RD_WAIT  = 5'h02,
        ST_RD_BURST = 5'h04,
        ST_WR_WAIT  = 5'h08,
        ST_WR_BURST = 5'h10
    } ddm_state_t;

    typedef struct packed {
        logic              chip_select_n;
        logic              row_strobe_n;
        logic              col_strobe_n;
        logic              write_enable_n;
        logic [BANK_W-1:0] bank_select;
        logic [ADDR_W-1:0] addr;
    } ddm_cmd_t;

    typedef struct packed {
        logic [DATA_W-1:0] data_lines;
        logic [BYTES-1:0]  byte_write_mask;
        logic [BYTES-1:0]  strobe;
    } ddm_wr_t;

    typedef struct packed {
        logic [DATA_W-1:0] data_rise;
        logic [DATA_W-1:0] data_fall;
        logic [BYTES-1:0]  strobe_rise;
        logic [BYTES-1:0]  strobe_fall;
        logic              data_oe;
        logic              strobe_oe;
    } ddm_rd_t;

endpackage

// [ddm_command_data_port.sv]
// Purpose: device side of a 64-bit double-data-rate module command and data port
// Assumes: pads merge rise/fall halves and resolve two-way pins from the enables
// Notes:   small flop array stands in for the cell array
//
// Overview of operation
// RULE1: positive clock edge is true clock rising while its complement falls.
// RULE2: command and address are captured only at positive link clock edges.
// RULE3: write data taken on both strobe edges; read data timed to both edges.
// RULE4: strobe driven by memory only during reads, by controller during writes.
// RULE5: read strobe edge-aligned with data; write strobe centred in data eye.
// RULE6: two data words move per clock on the data pins.
// RULE7: one double-width core access per clock, split into two half-cycle transfers.
// RULE8: 64-bit data path sharing one command and address bus.
// RULE9: controller activates a row before reading or writing that bank.
// RULE10: activate takes bank from bank_select and row from address lines.
// RULE11: read or write takes bank and starting column from the address.
// RULE12: burst starts at chosen column, runs programmed length in programmed order.
// RULE13: burst lengths of two, four or eight locations are supported.
// RULE14: auto precharge closes the row self-timed after the burst ends.
// RULE15: four independent banks; activate or precharge overlaps other bank access.
// RULE16: automatic refresh and a low-power power-down state are provided.
// RULE17: chip_select_n high masks all commands; low enables decoding.
// RULE18: a byte with its write mask high is not written; reads ignore masks.
// RULE19: precharge_all_bit asks auto precharge on access, all banks on precharge.
// RULE20: controller holds clock_enable_in high through reads and writes.
`timescale 1ns/100ps

module ddm_command_data_port #(
    parameter int ROW_BITS = 2,
    parameter int COL_BITS = 4
) (
    input  wire logic               clock,
    input  wire logic               rst_b,
    input  wire logic               clk_en,
    input  wire logic               link_clk,
    input  wire logic               clock_enable_in,
    input  wire ddm_pkg::ddm_cmd_t  cmd,
    input  wire ddm_pkg::ddm_wr_t   wr,
    output ddm_pkg::ddm_rd_t        rd,
    output logic [3:0]              bank_open_status,
    output logic                    power_down_status,
    output logic                    refresh_pulse
);

    localparam int MEM_AW = ddm_pkg::BANK_W + ROW_BITS + COL_BITS;
    localparam int DEPTH  = 1 << MEM_AW;

    // ==========================================================
    // burst addressing
    function automatic logic [2:0] burst_low(input logic [2:0] s, input logic [2:0] k,
                                             input logic [3:0] bl, input logic il);
        logic [2:0] m;
        logic [2:0] o;
        m = (bl == 4'h2) ? 3'h1 : (bl == 4'h4) ? 3'h3 : 3'h7;
        o = il ? (s ^ k) : 3'(s + k);
        return (s & ~m) | (o & m);
    endfunction

    function automatic logic [MEM_AW-1:0] mem_idx(input logic [1:0] b,
        input logic [ROW_BITS-1:0] r, input logic [COL_BITS-1:0] c,
        input logic [2:0] k, input logic [3:0] bl, input logic il);
        return {b, r, c[COL_BITS-1:3], burst_low(c[2:0], k, bl, il)};
    endfunction

    // ==========================================================
    // link domain: command decode
    ddm_pkg::ddm_op_t op;
    logic             cmd_on;
    logic             is_act, is_rd, is_wr, is_pre, is_ref, is_mrs;

    always_comb begin
        op     = ddm_pkg::ddm_op_t'({cmd.row_strobe_n, cmd.col_strobe_n, cmd.write_enable_n});
        cmd_on = ~cmd.chip_select_n;                             // RULE17
        is_act = cmd_on && (op == ddm_pkg::CMD_ACT);             // RULE2
        is_rd  = cmd_on && (op == ddm_pkg::CMD_RD);
        is_wr  = cmd_on && (op == ddm_pkg::CMD_WR);
        is_pre = cmd_on && (op == ddm_pkg::CMD_PRE);
        is_ref = cmd_on && (op == ddm_pkg::CMD_REF);
        is_mrs = cmd_on && (op == ddm_pkg::CMD_MRS);
    end

    // ==========================================================
    // link domain: per-bank row state
    logic [3:0]                      bank_open_reg, bank_open_next;
    logic [ddm_pkg::ADDR_W-1:0]      bank_row_reg  [ddm_pkg::BANKS];
    logic [ddm_pkg::ADDR_W-1:0]      bank_row_next [ddm_pkg::BANKS];
    logic [3:0]                      ap_cnt_reg [ddm_pkg::BANKS], ap_cnt_next [ddm_pkg::BANKS];
    logic                            ap_start;
    logic [1:0]                      acc_bank_reg;

    generate
        for (genvar b = 0; b < ddm_pkg::BANKS; b++) begin : g_bank
            logic hit;
            assign hit = (cmd.bank_select == 2'(b));
            always_comb begin
                bank_open_next[b] = bank_open_reg[b];
                bank_row_next[b]  = bank_row_reg[b];
                ap_cnt_next[b]    = ap_cnt_reg[b];
                if (ap_cnt_reg[b] != 4'h0) begin                 // RULE14
                    ap_cnt_next[b] = ap_cnt_reg[b] - 4'h1;
                    if (ap_cnt_reg[b] == 4'h1) begin
                        bank_open_next[b] = 1'b0;
                    end
                end
                if (ap_start && (acc_bank_reg == 2'(b))) begin
                    ap_cnt_next[b] = ddm_pkg::TRP_CYC;
                end
                if (is_pre && (cmd.addr[ddm_pkg::AP_BIT] || hit)) begin   // RULE19
                    bank_open_next[b] = 1'b0;
                    ap_cnt_next[b]    = 4'h0;
                end
                if (is_act && hit) begin                         // RULE10 RULE15
                    bank_open_next[b] = 1'b1;
                    bank_row_next[b]  = cmd.addr;
                end
            end

            always_ff @(posedge link_clk or negedge rst_b) begin
                if (!rst_b) begin
                    bank_open_reg[b] <= 1'b0;
                    bank_row_reg[b]  <= '0;
                    ap_cnt_reg[b]    <= 4'h0;
                end else if (clock_enable_in) begin
                    bank_open_reg[b] <= bank_open_next[b];
                    bank_row_reg[b]  <= bank_row_next[b];
                    ap_cnt_reg[b]    <= ap_cnt_next[b];
                end
            end
        end
    endgenerate

    // ==========================================================
    // link domain: first-half write capture on falling edge
    ddm_pkg::ddm_wr_t neg_reg;
    always_ff @(negedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            neg_reg <= '0;
        end else if (clock_enable_in) begin
            neg_reg <= wr;                                       // RULE3 RULE5
        end
    end

    // ==========================================================
    // link domain: burst engine, mode, refresh, storage
    ddm_pkg::ddm_state_t              state_reg, state_next;
    logic [1:0]                       acc_bank_next;
    logic [ROW_BITS-1:0]              acc_row_reg, acc_row_next;
    logic [COL_BITS-1:0]              acc_col_reg, acc_col_next;
    logic [3:0]                       beat_reg, beat_next;
    logic [1:0]                       wait_reg, wait_next;
    logic                             ap_reg, ap_next;
    logic [3:0]                       bl_reg, bl_next;
    logic                             il_reg, il_next;
    logic [1:0]                       cl_reg, cl_next;
    logic                             ref_tgl_reg, ref_tgl_next;
    ddm_pkg::ddm_rd_t                 rd_reg, rd_next;
    logic [ddm_pkg::DATA_W-1:0]       mem_reg [DEPTH], mem_next [DEPTH];
    logic                             pd_reg;
    logic [MEM_AW-1:0]                ia, ib;
    logic                             last;

    always_comb begin
        state_next    = state_reg;
        acc_bank_next = acc_bank_reg;
        acc_row_next  = acc_row_reg;
        acc_col_next  = acc_col_reg;
        beat_next     = beat_reg;
        wait_next     = wait_reg;
        ap_next       = ap_reg;
        bl_next       = bl_reg;
        il_next       = il_reg;
        cl_next       = cl_reg;
        ref_tgl_next  = ref_tgl_reg;
        mem_next      = mem_reg;
        rd_next       = rd_reg;
        rd_next.data_oe   = 1'b0;                                // RULE4
        rd_next.strobe_oe = 1'b0;
        ap_start      = 1'b0;
        ia   = mem_idx(acc_bank_reg, acc_row_reg, acc_col_reg, beat_reg[2:0], bl_reg, il_reg);
        ib   = mem_idx(acc_bank_reg, acc_row_reg, acc_col_reg, 3'(beat_reg + 4'h1),
                       bl_reg, il_reg);
        last = (4'(beat_reg + 4'h2) == bl_reg);
        case (state_reg)
            ddm_pkg::ST_IDLE: begin
                if ((is_rd || is_wr) && bank_open_reg[cmd.bank_select]) begin   // RULE9 RULE11
                    acc_bank_next = cmd.bank_select;
                    acc_row_next  = bank_row_reg[cmd.bank_select][ROW_BITS-1:0];
                    acc_col_next  = cmd.addr[COL_BITS-1:0];
                    ap_next       = cmd.addr[ddm_pkg::AP_BIT];                   // RULE19
                    beat_next     = 4'h0;
                    wait_next     = cl_reg - 2'h1;
                    state_next    = is_rd ? ddm_pkg::ST_RD_WAIT : ddm_pkg::ST_WR_WAIT;
                end
                if (is_mrs && (cmd.bank_select == 2'h0)) begin
                    case (cmd.addr[ddm_pkg::MR_BL_LSB +: 3])                    // RULE13
                        ddm_pkg::BL2_CODE: bl_next = 4'h2;
                        ddm_pkg::BL4_CODE: bl_next = 4'h4;
                        ddm_pkg::BL8_CODE: bl_next = 4'h8;
                        default:           bl_next = bl_reg;
                    endcase
                    il_next = cmd.addr[ddm_pkg::MR_BT_BIT];
                    case (cmd.addr[ddm_pkg::MR_CL_LSB +: 3])
                        ddm_pkg::CL2_CODE:  cl_next = 2'h2;
                        ddm_pkg::CL3_CODE:  cl_next = 2'h3;
                        ddm_pkg::CL25_CODE: cl_next = 2'h3;
                        default:            cl_next = cl_reg;
                    endcase
                end
                if (is_ref) begin                                                // RULE16
                    ref_tgl_next = ~ref_tgl_reg;
                end
            end
            ddm_pkg::ST_RD_WAIT: begin
                wait_next = wait_reg - 2'h1;
                if (wait_reg == 2'h1) begin
                    state_next = ddm_pkg::ST_RD_BURST;
                end
            end
            ddm_pkg::ST_RD_BURST: begin
                rd_next.data_rise   = mem_reg[ia];                               // RULE6 RULE7
                rd_next.data_fall   = mem_reg[ib];
                rd_next.strobe_rise = 8'hFF;                                     // RULE5
                rd_next.strobe_fall = 8'h00;
                rd_next.data_oe     = 1'b1;
                rd_next.strobe_oe   = 1'b1;
                beat_next = beat_reg + 4'h2;                                     // RULE12
                if (last) begin
                    state_next = ddm_pkg::ST_IDLE;
                    ap_start   = ap_reg;                                         // RULE14
                end
            end
            ddm_pkg::ST_WR_WAIT: begin
                state_next = ddm_pkg::ST_WR_BURST;
            end
            ddm_pkg::ST_WR_BURST: begin
                for (int j = 0; j < ddm_pkg::BYTES; j++) begin                   // RULE8
                    if (!neg_reg.byte_write_mask[j] && neg_reg.strobe[j]) begin  // RULE18 RULE3
                        mem_next[ia][j*8 +: 8] = neg_reg.data_lines[j*8 +: 8];
                    end
                    if (!wr.byte_write_mask[j] && !wr.strobe[j]) begin
                        mem_next[ib][j*8 +: 8] = wr.data_lines[j*8 +: 8];
                    end
                end
                beat_next = beat_reg + 4'h2;
                if (last) begin
                    state_next = ddm_pkg::ST_IDLE;
                    ap_start   = ap_reg;
                end
            end
            default: begin
                state_next = ddm_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk or negedge rst_b) begin               // RULE1
        if (!rst_b) begin
            state_reg    <= ddm_pkg::ST_IDLE;
            acc_bank_reg <= 2'h0;
            acc_row_reg  <= '0;
            acc_col_reg  <= '0;
            beat_reg     <= 4'h0;
            wait_reg     <= 2'h0;
            ap_reg       <= 1'b0;
            bl_reg       <= ddm_pkg::BL_RST;
            il_reg       <= ddm_pkg::BT_RST;
            cl_reg       <= ddm_pkg::CL_RST;
            ref_tgl_reg  <= 1'b0;
            rd_reg       <= '0;
            mem_reg      <= '{default: '0};
        end else if (clock_enable_in) begin
            state_reg    <= state_next;
            acc_bank_reg <= acc_bank_next;
            acc_row_reg  <= acc_row_next;
            acc_col_reg  <= acc_col_next;
            beat_reg     <= beat_next;
            wait_reg     <= wait_next;
            ap_reg       <= ap_next;
            bl_reg       <= bl_next;
            il_reg       <= il_next;
            cl_reg       <= cl_next;
            ref_tgl_reg  <= ref_tgl_next;
            rd_reg       <= rd_next;
            mem_reg      <= mem_next;
        end
    end

    // power-down flag keeps running while the rest is frozen
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            pd_reg <= 1'b0;
        end else begin
            pd_reg <= ~clock_enable_in;                                  // RULE16 RULE20
        end
    end
    assign rd = rd_reg;

    // ==========================================================
    // system domain: status crossing
    logic [3:0] open_s1_reg, open_s2_reg;
    logic       pd_s1_reg, pd_s2_reg;
    logic [2:0] tgl_sync_reg;
    logic [3:0] open_out_reg, open_out_next;
    logic       pd_out_reg, pd_out_next;
    logic       ref_out_reg, ref_out_next;

    always_comb begin
        open_out_next = open_s2_reg;
        pd_out_next   = pd_s2_reg;
        ref_out_next  = tgl_sync_reg[1] ^ tgl_sync_reg[2];
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            open_s1_reg  <= 4'h0;
            open_s2_reg  <= 4'h0;
            pd_s1_reg    <= 1'b0;
            pd_s2_reg    <= 1'b0;
            tgl_sync_reg <= 3'h0;
            open_out_reg <= 4'h0;
            pd_out_reg   <= 1'b0;
            ref_out_reg  <= 1'b0;
        end else if (clk_en) begin
            open_s1_reg  <= bank_open_reg;
            open_s2_reg  <= open_s1_reg;
            pd_s1_reg    <= pd_reg;
            pd_s2_reg    <= pd_s1_reg;
            tgl_sync_reg <= {tgl_sync_reg[1:0], ref_tgl_reg};
            open_out_reg <= open_out_next;
            pd_out_reg   <= pd_out_next;
            ref_out_reg  <= ref_out_next;
        end
    end

    assign bank_open_status  = open_out_reg;
    assign power_down_status = pd_out_reg;
    assign refresh_pulse     = ref_out_reg;

endmodule // ddm_command_data_port

// [ddm_command_data_port_properties.sv]
// Purpose: concurrent checks on the command and data port
// Assumes: read latency code 2 kept from reset
// Notes:   burst length tracked from accepted mode sets
`timescale 1ns/100ps
module ddm_port_checker (
    input wire logic              clock,
    input wire logic              rst_b,
    input wire logic              clk_en,
    input wire logic              link_clk,
    input wire logic              clock_enable_in,
    input wire ddm_pkg::ddm_cmd_t cmd,
    input wire ddm_pkg::ddm_wr_t  wr,
    input wire ddm_pkg::ddm_rd_t  rd,
    input wire logic [3:0]        bank_open_status,
    input wire logic              power_down_status,
    input wire logic              refresh_pulse
);
    logic [2:0] op, half_reg, half_next, cnt_reg, cnt_next;
    logic       rd_req, ms_req;
    assign op = {cmd.row_strobe_n, cmd.col_strobe_n, cmd.write_enable_n};
    assign rd_req = clock_enable_in && !cmd.chip_select_n && op == 3'h5;
    assign ms_req = clock_enable_in && !cmd.chip_select_n && op == 3'h0 && cmd.bank_select == 2'h0;
    // ==========================
    // burst half-length and beat count
    always_comb begin
        half_next = half_reg;
        cnt_next = 3'h0;
        if (ms_req && cmd.addr[2:0] inside {3'h1, 3'h2, 3'h3})
            half_next = 3'h1 << (cmd.addr[1:0] - 2'h1);
        if (rd.data_oe && cnt_reg != half_reg - 3'h1)
            cnt_next = cnt_reg + 3'h1;
    end
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            half_reg <= 3'h2;
            cnt_reg <= 3'h0;
        end else begin
            half_reg <= half_next;
            cnt_reg <= cnt_next;
        end
    end
    // ==========================
    // properties
    chk_oe_pair: assert property (@(posedge link_clk) disable iff (!rst_b)
        rd.data_oe == rd.strobe_oe) else $error("strobe and data enables differ");
    chk_strobe_shape: assert property (@(posedge link_clk) disable iff (!rst_b)
        rd.strobe_oe |-> rd.strobe_rise == 8'hFF && rd.strobe_fall == 8'h00)
        else $error("read strobe not edge aligned");
    chk_read_start: assert property (@(posedge link_clk) disable iff (!rst_b)
        $rose(rd.data_oe) |-> $past(rd_req, 3)) else $error("read data without read");
    chk_burst_len: assert property (@(posedge link_clk) disable iff (!rst_b)
        $fell(rd.data_oe) |-> cnt_reg == 3'h0) else $error("burst of wrong length");
    chk_cke_freeze: assert property (@(posedge link_clk) disable iff (!rst_b)
        !clock_enable_in |=> $stable(rd)) else $error("read port moved while frozen");
    chk_refresh_once: assert property (@(posedge clock) disable iff (!rst_b)
        refresh_pulse |=> !refresh_pulse) else $error("refresh pulse too long");
    chk_pd_enter: assert property (@(posedge clock) disable iff (!rst_b)
        !clock_enable_in [*8] |-> power_down_status) else $error("power-down missing");
    chk_pd_exit: assert property (@(posedge clock) disable iff (!rst_b)
        clock_enable_in [*8] |-> !power_down_status) else $error("power-down stuck");
    cover property (@(posedge link_clk) $rose(rd.data_oe));
    cover property (@(posedge clock) refresh_pulse);
    cover property (@(posedge clock) bank_open_status == 4'hF);
endmodule // ddm_port_checker

bind ddm_command_data_port ddm_port_checker chk_u (.clock(clock), .rst_b(rst_b),
    .clk_en(clk_en), .link_clk(link_clk), .clock_enable_in(clock_enable_in), .cmd(cmd),
    .wr(wr), .rd(rd), .bank_open_status(bank_open_status),
    .power_down_status(power_down_status), .refresh_pulse(refresh_pulse));

// [ddm_host_model.sv]
// Purpose: controller model driving commands and write data
// Assumes: lines change just after a link clock edge
// Notes:   released lines show inverted values
`timescale 1ns/100ps
module ddm_host_model (
    input  wire logic         link_clk,
    output ddm_pkg::ddm_cmd_t cmd,
    output ddm_pkg::ddm_wr_t  wr
);
    logic [63:0] wq[$];
    logic [7:0]  mq[$];
    initial begin
        cmd = '1;
        wr = '0;
    end
    // ==========================
    // command, then write beats
    task automatic send(input logic [2:0] op, input logic [1:0] ba, input logic [12:0] a);
        @(posedge link_clk);
        cmd <= {1'b0, op, ba, a};
        @(posedge link_clk);
        cmd <= {1'b1, ~op, ~ba, ~a};
        if (op == 3'h4) begin
            @(posedge link_clk);
            foreach (wq[i]) begin
                wr <= {wq[i], mq[i], {8{~i[0]}}};
                if (i[0]) @(posedge link_clk);
                else @(negedge link_clk);
            end
            wr <= ~wr;
            wq.delete();
            mq.delete();
        end
    endtask
endmodule // ddm_host_model

// [tb_ddr_sdram_module_command_data_port.sv]
// Purpose: self-checking bench for the command and data port
// Assumes: read latency 2, write latency 1
// Notes:   read pairs compared against an expectation queue
`timescale 1ns/100ps
module tb_ddr_sdram_module_command_data_port;
    logic              clock = 1'b0;
    logic              link_clk = 1'b0;
    logic              rst_b = 1'b0;
    logic              clock_enable_in = 1'b1;
    ddm_pkg::ddm_cmd_t cmd;
    ddm_pkg::ddm_wr_t  wr;
    ddm_pkg::ddm_rd_t  rd;
    logic [3:0]        bank_open_status;
    logic              power_down_status, refresh_pulse;
    logic [127:0]      exp_q[$], exp_v;
    logic [63:0]       mem[int];
    logic [1:0]        row_of[4];
    bit                open_b[4];
    int                fails = 0, checks_done = 0, pulses = 0, seed = 32'h7ED95242;
    always #5 clock = ~clock;
    always #7.5 link_clk = ~link_clk;
    ddm_command_data_port dut_u (.clock(clock), .rst_b(rst_b), .clk_en(1'b1),
        .link_clk(link_clk), .clock_enable_in(clock_enable_in), .cmd(cmd), .wr(wr), .rd(rd),
        .bank_open_status(bank_open_status), .power_down_status(power_down_status),
        .refresh_pulse(refresh_pulse));
    ddm_host_model hm_u (.link_clk(link_clk), .cmd(cmd), .wr(wr));
    // ==========================
    // checking and closing
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ==========================
    // one burst: notes writes into mem, reads into the queue
    task automatic burst(input int ba, input int a, input int bl, input bit il, input bit w,
                         input bit msk);
        int c;
        logic [63:0] d, r;
        logic [7:0] m;
        for (int k = 0; k < bl; k++) begin
            c = (a & 15 & ~(bl - 1)) | ((il ? (a ^ k) : (a + k)) & (bl - 1));
            c = ba * 64 + row_of[ba] * 16 + c;
            if (w) begin
                d = {$random(seed), $random(seed)};
                m = msk ? 8'($random(seed)) : 8'h00;
                hm_u.wq.push_back(d);
                hm_u.mq.push_back(m);
                for (int b = 0; b < 8; b++)
                    if (!m[b]) mem[c][8*b +: 8] = d[8*b +: 8];
            end else if (open_b[ba]) begin
                d = mem.exists(c) ? mem[c] : 64'h0;
                if (k[0]) exp_q.push_back({r, d});
                else r = d;
            end
        end
        hm_u.send(w ? 3'h4 : 3'h5, 2'(ba), 13'(a));
        if (a[10]) open_b[ba] = 1'b0;
        repeat (bl / 2 + 4) @(posedge link_clk);
    endtask
    always @(posedge link_clk) begin
        if (rd.data_oe === 1'b1) begin
            exp_v = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            check({rd.data_rise, rd.data_fall}, exp_v);
        end
    end
    always @(posedge clock) if (refresh_pulse === 1'b1) pulses++;
    initial begin
        #60000;
        fails++;
        end_of_test();
    end
    // ==========================
    // main sequence
    initial begin
        int bl, col;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bl = 2 << (i % 3);
            col = $random(seed) & 15;
            hm_u.send(3'h2, 2'h0, 13'h400);
            hm_u.send(3'h0, 2'h0, 13'(i % 3 + 1 + (i / 3) * 8) | 13'h20);
            row_of[i % 4] = 2'($random(seed));
            open_b[i % 4] = 1'b1;
            hm_u.send(3'h3, 2'(i % 4), 13'(row_of[i % 4]));
            burst(i % 4, col, bl, 1'(i / 3), 1'b1, 1'b0);
            burst(i % 4, col, bl, 1'(i / 3), 1'b1, 1'b1);
            burst(i % 4, col, bl, 1'(i / 3), 1'b0, 1'b0);
        end
        for (int b = 0; b < 4; b++) begin
            open_b[b] = 1'b1;
            hm_u.send(3'h3, 2'(b), 13'(row_of[b]));
        end
        repeat (10) @(posedge clock);
        check(128'(bank_open_status), 128'hF);
        burst(0, col | 13'h400, 8, 1'b1, 1'b1, 1'b0);
        hm_u.send(3'h2, 2'h1, 13'h0);
        open_b[1] = 1'b0;
        burst(0, col, 8, 1'b1, 1'b0, 1'b0);
        burst(1, col, 8, 1'b1, 1'b0, 1'b0);
        burst(2, col, 8, 1'b1, 1'b0, 1'b0);
        check(128'(bank_open_status), 128'hC);
        hm_u.send(3'h2, 2'h0, 13'h400);
        hm_u.send(3'h1, 2'h0, 13'h0);
        repeat (10) @(posedge clock);
        check(128'(bank_open_status), 128'h0);
        check(128'(pulses), 128'h1);
        @(posedge link_clk) clock_enable_in <= 1'b0;
        repeat (12) @(posedge clock);
        check(128'(power_down_status), 128'h1);
        @(posedge link_clk) clock_enable_in <= 1'b1;
        repeat (12) @(posedge clock);
        check(128'(power_down_status), 128'h0);
        check(128'(exp_q.size()), 128'h0);
        end_of_test();
    end
endmodule // tb_ddr_sdram_module_command_data_port
